// File: common/tfp_pkg.sv
// Purpose: shared constants for the two-wire flash programming link
// Assumes: both ends and the bench import the whole package
// Notes: link frame = start bit, two op bits, eight data bits, msb first
package tfp_pkg;
  // register select codes held in the link's register-select register
  localparam logic [7:0] SEL_PART_ID = 8'h00;
  localparam logic [7:0] SEL_REVISION = 8'h01;
  localparam logic [7:0] SEL_UNLOCK = 8'h02;
  localparam logic [7:0] SEL_DATA_CMD = 8'hB4;
  // ordered unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h02;
  localparam logic [7:0] KEY_SECOND = 8'h01;
  // flash command codes
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  // reset values
  localparam logic [7:0] UNLOCK_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;
  // frame opcodes, op[1] set means a read
  typedef enum logic [1:0] {
    OP_ADDR_WR = 2'b00,
    OP_DATA_WR = 2'b01,
    OP_ADDR_RD = 2'b10,
    OP_DATA_RD = 2'b11
  } tfp_op_t;
  // host register map (byte addresses)
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RDATA = 12'h008;
  localparam logic [11:0] REG_RESET = 12'h00C;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RST = 1;
  localparam int STAT_HALT = 2;
  localparam int RESET_GO = 0;
  // timing counts in ref_clk cycles
  localparam int DEF_HALF_DIV = 6;
  localparam int DEF_RST_LOW_CYC = 64;
  localparam int DEF_RST_STRETCH_CYC = 64;
  localparam int DEF_RST_HOLD_CYC = 256;
  localparam int DEF_POST_RST_CYC = 256;
  localparam int CNT_W = 16;
endpackage

// File: common/tfp_link_if.sv
// Purpose: the two link wires between programmer and target
// Assumes: data wire is pulled high when nobody drives it
// Notes: the clock wire doubles as the target's active-low reset
`timescale 1ns/1ps
interface tfp_link_if;
  logic link_clock_pin;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic link_data_pin;
  // wire level resolved from the enables, pull-up when idle
  assign link_data_pin = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 1'b1);
  modport host (output link_clock_pin, output host_data_o, output host_data_oe,
                input link_data_pin);
  modport dev (input link_clock_pin, output dev_data_o, output dev_data_oe,
               input link_data_pin);
endinterface

// File: src/tfp_dev_end.sv
// Purpose: target end of the two-wire flash programming link
// Assumes: host drives data on clock low, target samples on clock rise
// Notes: link logic runs on the link clock, user side on ref_clk
// Notes on behaviour
// - register-select code picks later data target
// - host clock plus one shared data wire
// - part id read returns fixed code
// - revision read returns die revision, read-only
// - programming enabled only after keys 02, 01
// - enabled state held until system reset
// - data register streams command, address, data bytes
// - only four flash command codes accepted
// - link traffic only while target halted
// - link borrows both pins while halted
// - isolated user logic holds data steady
// - user application uses reset pin as input
`timescale 1ns/1ps
module tfp_dev_end
  import tfp_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01, // arbitrary value
  parameter int RST_LOW_CYC = DEF_RST_LOW_CYC,
  parameter int RST_STRETCH_CYC = DEF_RST_STRETCH_CYC
) (
  // link
  tfp_link_if.dev lnk,
  // core clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // core status
  input wire logic halted,
  input wire logic flash_cmd_ready,
  // flash read bytes from the core
  input wire logic flash_rd_stb,
  input wire logic [7:0] flash_rd_byte,
  // flash bytes to the core
  output logic flash_wr_stb,
  output logic flash_wr_is_cmd,
  output logic [7:0] flash_wr_byte,
  // status
  output logic prog_enabled,
  output logic pins_borrowed,
  output logic sys_reset_req
);
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_OP1 = 3'b001,
    L_OP0 = 3'b010,
    L_WBIT = 3'b011,
    L_TURN = 3'b100,
    L_RBIT = 3'b101
  } tfp_lst_t;
  typedef enum logic [1:0] {
    K_LOCKED = 2'b00,
    K_FIRST = 2'b01,
    K_OPEN = 2'b10
  } tfp_key_t;

  // ---------------- core domain ----------------
  logic lck_s1_r, lck_s2_r, pe_s1_r, pe_s2_r, wt_s1_r, wt_s2_r, wt_s3_r;
  logic [CNT_W-1:0] low_r, low_nxt, str_r, str_nxt;
  logic rst_req_r, rst_req_nxt, held;
  logic wr_stb_r, wr_stb_nxt, wr_cmd_r, wr_cmd_nxt, rd_tog_r, rd_tog_nxt, pb_r;
  logic [7:0] wr_out_r, wr_out_nxt, rd_hold_r, rd_hold_nxt;
  // link-domain registers read across the crossing
  logic wr_tog_r, wr_is_cmd_r, key_open;
  logic [7:0] wr_byte_r;

  // reset detect: clock pin held low far longer than a half period
  always_comb begin
    held = !lck_s2_r && (low_r == CNT_W'(RST_LOW_CYC));
    low_nxt = lck_s2_r ? '0 : (held ? low_r : low_r + 1'b1);
    str_nxt = held ? CNT_W'(RST_STRETCH_CYC) : ((str_r != '0) ? str_r - 1'b1 : '0);
    // stretched so the link domain sees it once the clock runs again
    rst_req_nxt = srst || held || (str_r != '0);
    wr_stb_nxt = (wt_s2_r != wt_s3_r);
    wr_out_nxt = wr_stb_nxt ? wr_byte_r : wr_out_r; // stable: loaded on the toggle's edge, read two flops later
    wr_cmd_nxt = wr_stb_nxt ? wr_is_cmd_r : wr_cmd_r;
    rd_tog_nxt = flash_rd_stb ? !rd_tog_r : rd_tog_r;
    rd_hold_nxt = flash_rd_stb ? flash_rd_byte : rd_hold_r;
  end

  // core registers, synchronisers first stage read only by second
  always_ff @(posedge ref_clk) begin
    lck_s1_r <= lnk.link_clock_pin;
    lck_s2_r <= lck_s1_r;
    pe_s1_r <= key_open;
    pe_s2_r <= pe_s1_r;
    wt_s1_r <= wr_tog_r;
    wt_s2_r <= wt_s1_r;
    wt_s3_r <= wt_s2_r;
    if (srst) begin
      low_r <= '0;
      // stretch follows srst too: the link clock is still during srst
      str_r <= CNT_W'(RST_STRETCH_CYC);
      rst_req_r <= 1'b1;
      wr_stb_r <= 1'b0;
      wr_cmd_r <= 1'b0;
      wr_out_r <= DATA_RESET;
      rd_tog_r <= 1'b0;
      rd_hold_r <= DATA_RESET;
      pb_r <= 1'b0;
    end else begin
      low_r <= low_nxt;
      str_r <= str_nxt;
      rst_req_r <= rst_req_nxt;
      wr_stb_r <= wr_stb_nxt;
      wr_cmd_r <= wr_cmd_nxt;
      wr_out_r <= wr_out_nxt;
      rd_tog_r <= rd_tog_nxt;
      rd_hold_r <= rd_hold_nxt;
      pb_r <= halted;
    end
  end

  assign flash_wr_stb = wr_stb_r;
  assign flash_wr_is_cmd = wr_cmd_r;
  assign flash_wr_byte = wr_out_r;
  assign prog_enabled = pe_s2_r;
  assign pins_borrowed = pb_r;
  assign sys_reset_req = rst_req_r;

  // ---------------- link domain ----------------
  logic lr_s1_r, lr_s2_r, h_s1_r, h_s2_r, fr_s1_r, fr_s2_r, rt_s1_r, rt_s2_r, rt_s3_r;
  tfp_lst_t st_r, st_nxt;
  tfp_key_t key_r, key_nxt;
  logic op1_r, op1_nxt, op0_r, op0_nxt, oe_r, oe_nxt, do_r, do_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, sel_r, sel_nxt, unl_r, unl_nxt, rdl_r, rdl_nxt;
  logic [7:0] wb_nxt, byte_in, rd_val;
  logic wt_nxt, wc_nxt, din, valid_cmd;

  assign din = lnk.link_data_pin;
  assign byte_in = {sh_r[6:0], din};
  assign key_open = (key_r == K_OPEN);
  assign valid_cmd = (byte_in == CMD_BLOCK_READ) || (byte_in == CMD_BLOCK_WRITE) ||
                     (byte_in == CMD_PAGE_ERASE) || (byte_in == CMD_DEVICE_ERASE);

  // read mux over the selected register
  always_comb begin
    case (sel_r)
      SEL_PART_ID: rd_val = PART_ID;
      SEL_REVISION: rd_val = REV_ID;
      SEL_UNLOCK: rd_val = unl_r;
      SEL_DATA_CMD: rd_val = rdl_r;
      default: rd_val = 8'h00;
    endcase
  end

  // frame engine, one step per rising link clock edge
  always_comb begin
    st_nxt = st_r;
    key_nxt = key_r;
    op1_nxt = op1_r;
    op0_nxt = op0_r;
    oe_nxt = oe_r;
    do_nxt = do_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    sel_nxt = sel_r;
    unl_nxt = unl_r;
    rdl_nxt = (rt_s2_r != rt_s3_r) ? rd_hold_r : rdl_r; // held stable by core
    wb_nxt = wr_byte_r;
    wt_nxt = wr_tog_r;
    wc_nxt = wr_is_cmd_r;
    case (st_r)
      L_IDLE: begin
        if (!din && h_s2_r) begin
          st_nxt = L_OP1;
        end
      end
      L_OP1: begin
        op1_nxt = din;
        st_nxt = L_OP0;
      end
      L_OP0: begin
        op0_nxt = din;
        cnt_nxt = BIT_MSB;
        if (op1_r) begin
          sh_nxt = din ? rd_val : sel_r;
          st_nxt = L_TURN;
        end else begin
          st_nxt = L_WBIT;
        end
      end
      L_WBIT: begin
        sh_nxt = byte_in;
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == BIT_LSB) begin
          st_nxt = L_IDLE;
          if (!op0_r) begin
            sel_nxt = byte_in;
          end else if (sel_r == SEL_UNLOCK) begin
            unl_nxt = byte_in;
            // keys in order, anything else drops back to locked until open; once open any byte keeps it open
            case (key_r)
              K_LOCKED: key_nxt = (byte_in == KEY_FIRST) ? K_FIRST : K_LOCKED;
              K_FIRST: key_nxt = (byte_in == KEY_SECOND) ? K_OPEN : K_LOCKED;
              K_OPEN: key_nxt = K_OPEN;
              default: key_nxt = K_LOCKED;
            endcase
          end else if (sel_r == SEL_DATA_CMD && key_open && (valid_cmd || !fr_s2_r)) begin
            wb_nxt = byte_in;
            wc_nxt = fr_s2_r;
            wt_nxt = !wr_tog_r;
          end
        end
      end
      L_TURN: begin
        // host released the wire during the previous period
        oe_nxt = h_s2_r;
        do_nxt = sh_r[7];
        sh_nxt = {sh_r[6:0], 1'b0};
        st_nxt = L_RBIT;
      end
      L_RBIT: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == BIT_LSB) begin
          oe_nxt = 1'b0;
          do_nxt = 1'b1;
          st_nxt = L_IDLE;
        end else begin
          do_nxt = sh_r[7];
          sh_nxt = {sh_r[6:0], 1'b0};
        end
      end
      default: st_nxt = L_IDLE;
    endcase
  end

  // link registers; reset arrives through a two-stage synchroniser
  always_ff @(posedge lnk.link_clock_pin) begin
    lr_s1_r <= rst_req_r;
    lr_s2_r <= lr_s1_r;
    h_s1_r <= halted;
    h_s2_r <= h_s1_r;
    fr_s1_r <= flash_cmd_ready;
    fr_s2_r <= fr_s1_r;
    rt_s1_r <= rd_tog_r;
    rt_s2_r <= rt_s1_r;
    rt_s3_r <= rt_s2_r;
    if (lr_s2_r) begin
      st_r <= L_IDLE;
      key_r <= K_LOCKED;
      op1_r <= 1'b0;
      op0_r <= 1'b0;
      oe_r <= 1'b0;
      do_r <= 1'b1;
      cnt_r <= BIT_MSB;
      sh_r <= DATA_RESET;
      sel_r <= SEL_RESET;
      unl_r <= UNLOCK_RESET;
      rdl_r <= DATA_RESET;
      wr_byte_r <= DATA_RESET;
      wr_is_cmd_r <= 1'b0;
      wr_tog_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      key_r <= key_nxt;
      op1_r <= op1_nxt;
      op0_r <= op0_nxt;
      oe_r <= oe_nxt;
      do_r <= do_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      sel_r <= sel_nxt;
      unl_r <= unl_nxt;
      rdl_r <= rdl_nxt;
      wr_byte_r <= wb_nxt;
      wr_is_cmd_r <= wc_nxt;
      wr_tog_r <= wt_nxt;
    end
  end

  assign lnk.dev_data_o = do_r;
  assign lnk.dev_data_oe = oe_r;
endmodule

// File: src/tfp_host_end.sv
// Purpose: programmer end: apb registers driving the two-wire link
// Assumes: pclk is ref_clk; link clock made by dividing ref_clk
// Notes: one frame at a time; software polls the busy bit
`timescale 1ns/1ps
module tfp_host_end
  import tfp_pkg::*;
#(
  parameter int HALF_DIV = DEF_HALF_DIV,
  parameter int RST_HOLD_CYC = DEF_RST_HOLD_CYC,
  parameter int POST_RST_CYC = DEF_POST_RST_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // target state
  input wire logic target_halted,
  // link
  tfp_link_if.host lnk
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_OP1 = 4'b0001,
    H_OP0 = 4'b0010,
    H_WBIT = 4'b0011,
    H_TURN = 4'b0100,
    H_RBIT = 4'b0101,
    H_RGAP = 4'b0110,
    H_RST = 4'b0111,
    H_POST = 4'b1000
  } tfp_hst_t;

  tfp_hst_t st_r, st_nxt;
  logic [CNT_W-1:0] div_r, div_nxt, tmr_r, tmr_nxt;
  logic clk_r, clk_nxt, go_r, go_nxt, do_r, do_nxt, oe_r, oe_nxt;
  logic ds1_r, ds2_r, hs1_r, hs2_r;
  logic [1:0] op_r, op_nxt;
  logic [7:0] wb_r, wb_nxt, rb_r, rb_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic acc, busy, tick, fall, cmd_ok, rst_ok, bad_addr;

  assign acc = psel && penable;
  assign busy = (st_r != H_IDLE) || go_r;
  assign tick = (div_r == CNT_W'(HALF_DIV - 1));
  assign fall = tick && clk_r;
  assign cmd_ok = !busy && hs2_r;
  assign rst_ok = (st_r == H_IDLE) && !go_r;
  assign bad_addr = (paddr != REG_CMD) && (paddr != REG_STATUS) &&
                    (paddr != REG_RDATA) && (paddr != REG_RESET);
  // zero wait states; refused writes flagged with an error
  assign pready = 1'b1;
  assign pslverr = acc && (bad_addr ||
                   (pwrite && paddr == REG_CMD && !cmd_ok) ||
                   (pwrite && paddr == REG_RESET && !rst_ok));
  assign prdata = prd_r;

  // link sequencer; frame steps happen as the link clock falls, reset states run on the timer
  always_comb begin
    st_nxt = st_r;
    div_nxt = tick ? '0 : div_r + 1'b1;
    clk_nxt = tick ? !clk_r : clk_r;
    tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : '0;
    go_nxt = go_r;
    do_nxt = do_r;
    oe_nxt = oe_r;
    op_nxt = op_r;
    wb_nxt = wb_r;
    rb_nxt = rb_r;
    cnt_nxt = cnt_r;
    prd_nxt = prd_r;
    if (psel && !penable) begin
      prd_nxt = '0;
      case (paddr)
        REG_CMD: begin
          prd_nxt[CMD_OP_LSB +: 2] = op_r;
          prd_nxt[CMD_DATA_LSB +: 8] = wb_r;
        end
        REG_STATUS: begin
          prd_nxt[STAT_BUSY] = busy;
          prd_nxt[STAT_RST] = (st_r == H_RST) || (st_r == H_POST);
          prd_nxt[STAT_HALT] = hs2_r;
        end
        REG_RDATA: prd_nxt[7:0] = rb_r;
        default: prd_nxt = '0;
      endcase
    end
    if (acc && pwrite && paddr == REG_CMD && cmd_ok) begin
      op_nxt = pwdata[CMD_OP_LSB +: 2];
      wb_nxt = pwdata[CMD_DATA_LSB +: 8];
      go_nxt = 1'b1;
    end
    if (acc && pwrite && paddr == REG_RESET && rst_ok && pwdata[RESET_GO]) begin
      st_nxt = H_RST;
      tmr_nxt = CNT_W'(RST_HOLD_CYC);
    end
    case (st_r)
      H_RST: begin
        // clock pin held low acts as the target's reset; a high phase in
        // progress runs out first so the target never sees a short pulse
        if (!clk_r) begin
          div_nxt = '0;
          clk_nxt = 1'b0;
        end
        if (tmr_r == '0) begin
          st_nxt = H_POST;
          tmr_nxt = CNT_W'(POST_RST_CYC);
        end
      end
      H_POST: begin
        if (tmr_r == '0) begin
          st_nxt = H_IDLE;
        end
      end
      default: begin
        if (fall) begin
          case (st_r)
            H_IDLE: begin
              do_nxt = !go_r;
              oe_nxt = 1'b1;
              if (go_r) begin
                go_nxt = 1'b0;
                st_nxt = H_OP1;
              end
            end
            H_OP1: begin
              do_nxt = op_r[1];
              st_nxt = H_OP0;
            end
            H_OP0: begin
              do_nxt = op_r[0];
              cnt_nxt = BIT_MSB;
              st_nxt = op_r[1] ? H_TURN : H_WBIT;
            end
            H_WBIT: begin
              do_nxt = wb_r[cnt_r];
              cnt_nxt = cnt_r - 1'b1;
              if (cnt_r == BIT_LSB) begin
                st_nxt = H_IDLE;
              end
            end
            H_TURN: begin
              oe_nxt = 1'b0; // target drives from the next rise
              st_nxt = H_RBIT;
            end
            H_RBIT: begin
              if (oe_r) begin
                oe_nxt = 1'b0;
              end else begin
                rb_nxt = {rb_r[6:0], ds2_r};
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == BIT_LSB) begin
                  st_nxt = H_RGAP;
                end
              end
            end
            H_RGAP: begin
              // one idle period so the target lets go first
              do_nxt = 1'b1;
              oe_nxt = 1'b1;
              st_nxt = H_IDLE;
            end
            default: st_nxt = H_IDLE;
          endcase
        end
      end
    endcase
  end

  // registers; data pin and halt input pass two flops first
  always_ff @(posedge ref_clk) begin
    ds1_r <= lnk.link_data_pin;
    ds2_r <= ds1_r;
    hs1_r <= target_halted;
    hs2_r <= hs1_r;
    if (srst) begin
      st_r <= H_IDLE;
      div_r <= '0;
      tmr_r <= '0;
      clk_r <= 1'b0;
      go_r <= 1'b0;
      do_r <= 1'b1;
      oe_r <= 1'b1;
      op_r <= OP_ADDR_WR;
      wb_r <= DATA_RESET;
      rb_r <= DATA_RESET;
      cnt_r <= BIT_MSB;
      prd_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      tmr_r <= tmr_nxt;
      clk_r <= clk_nxt;
      go_r <= go_nxt;
      do_r <= do_nxt;
      oe_r <= oe_nxt;
      op_r <= op_nxt;
      wb_r <= wb_nxt;
      rb_r <= rb_nxt;
      cnt_r <= cnt_nxt;
      prd_r <= prd_nxt;
    end
  end

  assign lnk.link_clock_pin = clk_r;
  assign lnk.host_data_o = do_r;
  assign lnk.host_data_oe = oe_r;
endmodule

// File: tb/tfp_link_monitor.sv
// Purpose: wire-level checks on the two-wire link between both ends
// Assumes: sampled on ref_clk; the link clock comes from the host divider
// Notes: phase lengths are counted in helper logic, not by long repetition
`timescale 1ns/1ps
module tfp_link_monitor #(
  parameter int HALF_DIV = 6,
  parameter int RST_HOLD_CYC = 256
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // link wires
  input wire logic link_clock_pin,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic link_data_pin
);
  localparam int TURN_MAX = 40;
  logic [15:0] hi_cnt_r, hi_cnt_nxt, lo_cnt_r, lo_cnt_nxt, oe_cnt_r, oe_cnt_nxt;
  // target link side is undefined until its third link clock rise after srst
  logic lck_d_r;
  logic [1:0] rise_n_r, rise_n_nxt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst || rise_n_r != 2'h3);

  // phase and drive lengths, cleared whenever the level flips
  always_comb begin
    hi_cnt_nxt = link_clock_pin ? hi_cnt_r + 16'h0001 : 16'h0000;
    lo_cnt_nxt = link_clock_pin ? 16'h0000 : lo_cnt_r + 16'h0001;
    oe_cnt_nxt = dev_data_oe ? oe_cnt_r + 16'h0001 : 16'h0000;
    rise_n_nxt = (link_clock_pin && !lck_d_r && rise_n_r != 2'h3) ? rise_n_r + 2'h1 : rise_n_r;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hi_cnt_r <= 16'h0000;
      lo_cnt_r <= 16'h0000;
      oe_cnt_r <= 16'h0000;
      lck_d_r <= 1'b0;
      rise_n_r <= 2'h0;
    end else begin
      lck_d_r <= link_clock_pin;
      rise_n_r <= rise_n_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      oe_cnt_r <= oe_cnt_nxt;
    end
  end

  property p_no_fight; !(host_data_oe && dev_data_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_host_chg_low; host_data_oe && $changed(host_data_o) |-> !link_clock_pin; endproperty
  a_host_chg_low: assert property (p_host_chg_low) else $error("host data moved, clock high");
  property p_dev_chg_high;
    dev_data_oe && $past(dev_data_oe) && $changed(dev_data_o) |-> link_clock_pin;
  endproperty
  a_dev_chg_high: assert property (p_dev_chg_high) else $error("target data moved, clock low");
  property p_half; $fell(link_clock_pin) |-> hi_cnt_r == HALF_DIV; endproperty
  a_half: assert property (p_half) else $error("link clock high phase wrong");
  property p_turn; $fell(host_data_oe) |-> ##[1:TURN_MAX] dev_data_oe; endproperty
  a_turn: assert property (p_turn) else $error("target did not answer a read");
  property p_read_len;
    $fell(dev_data_oe) |-> oe_cnt_r >= 15 * HALF_DIV && oe_cnt_r <= 17 * HALF_DIV;
  endproperty
  a_read_len: assert property (p_read_len) else $error("target drove wrong bit count");
  property p_rst_hold;
    $rose(link_clock_pin) && lo_cnt_r > 2 * HALF_DIV |-> lo_cnt_r >= RST_HOLD_CYC;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("link reset low too short");
  property p_quiet_rst; lo_cnt_r > 2 * HALF_DIV |-> !dev_data_oe; endproperty
  a_quiet_rst: assert property (p_quiet_rst) else $error("target drives during reset");

  // main scenarios reached
  c_rst: cover property ($rose(link_clock_pin) && lo_cnt_r >= RST_HOLD_CYC);
  c_dev_low: cover property (dev_data_oe && !link_data_pin);
  c_turn: cover property ($fell(host_data_oe));
endmodule

// File: tb/two_wire_flash_prog_regs_tb_top.sv
// Purpose: drives the programmer over apb and the target's core side
// Assumes: target halted unless a scenario says otherwise
// Notes: link counts shortened by parameters to keep the run short
`timescale 1ns/1ps
module two_wire_flash_prog_regs_tb_top
  import tfp_pkg::*;
;
  localparam int HD = 4;
  localparam int HOLD = 100;
  localparam logic [7:0] PID = 8'h3C; // arbitrary value
  localparam logic [7:0] RID = 8'h07; // arbitrary value
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, perr, halted, cmd_rdy, rd_stb;
  logic wr_stb, wr_cmd, prog_en, borrowed, sys_rst, stb_cmd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] rd_byte, wr_byte, stb_byte;
  int stb_n, mismatches, compares;
  // no user logic on the wires: reset pin only an input, data held by pull-up
  tfp_link_if lnk ();

  tfp_host_end #(.HALF_DIV(HD), .RST_HOLD_CYC(HOLD), .POST_RST_CYC(100)) i_tfp_host_end (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .target_halted(halted), .lnk(lnk));
  tfp_dev_end #(.PART_ID(PID), .REV_ID(RID), .RST_LOW_CYC(20), .RST_STRETCH_CYC(40))
    i_tfp_dev_end (
    .lnk(lnk), .ref_clk(ref_clk), .srst(srst), .halted(halted), .flash_cmd_ready(cmd_rdy),
    .flash_rd_stb(rd_stb), .flash_rd_byte(rd_byte), .flash_wr_stb(wr_stb),
    .flash_wr_is_cmd(wr_cmd), .flash_wr_byte(wr_byte), .prog_enabled(prog_en),
    .pins_borrowed(borrowed), .sys_reset_req(sys_rst));
  tfp_link_monitor #(.HALF_DIV(HD), .RST_HOLD_CYC(HOLD)) i_tfp_link_monitor (
    .ref_clk(ref_clk), .srst(srst), .link_clock_pin(lnk.link_clock_pin),
    .host_data_o(lnk.host_data_o), .host_data_oe(lnk.host_data_oe),
    .dev_data_o(lnk.dev_data_o), .dev_data_oe(lnk.dev_data_oe),
    .link_data_pin(lnk.link_data_pin));

  // 200 mhz core clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // record every byte the target hands to the flash core
  always @(posedge ref_clk) begin
    if (wr_stb === 1'b1) begin
      stb_n <= stb_n + 1;
      stb_byte <= wr_byte;
      stb_cmd <= wr_cmd;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; idles a cycle after so psel is never set twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // no cycle count assumed: ends once pready is seen, otherwise only the watchdog ends it
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    rv = 32'h0000_0001;
    while (rv[STAT_BUSY] !== 1'b0 && n < 400) begin
      n++;
      apb(1'b0, REG_STATUS, 32'h0000_0000);
    end
    chk(rv[STAT_BUSY], 1'b0);
  endtask

  task automatic frame(input tfp_op_t op, input logic [7:0] b);
    apb(1'b1, REG_CMD, {16'h0000, b, 6'h00, op});
    wait_idle();
    // busy drops as bit 0 is driven; target samples it and syncs to the core later
    repeat (3 * HD) @(posedge ref_clk);
  endtask

  task automatic lwr(input logic [7:0] sel, input logic [7:0] b);
    frame(OP_ADDR_WR, sel);
    frame(OP_DATA_WR, b);
  endtask

  task automatic lrd(input logic [7:0] sel, input logic [7:0] exp);
    frame(OP_ADDR_WR, sel);
    frame(OP_DATA_RD, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0000_0000);
    chk(rv[7:0], exp);
  endtask

  task automatic t_ids();
    lrd(SEL_PART_ID, PID);
    lrd(SEL_REVISION, RID);
    lwr(SEL_PART_ID, 8'h5A);
    lwr(SEL_REVISION, 8'h5A);
    lrd(SEL_PART_ID, PID);
    lrd(SEL_REVISION, RID);
  endtask

  // locked writes go nowhere; broken key orders must not open the flash
  task automatic t_unlock();
    lwr(SEL_DATA_CMD, CMD_BLOCK_WRITE);
    chk(stb_n, 0);
    lwr(SEL_UNLOCK, KEY_FIRST);
    lwr(SEL_UNLOCK, KEY_FIRST);
    lwr(SEL_UNLOCK, KEY_SECOND);
    chk(prog_en, 1'b0);
    lwr(SEL_UNLOCK, KEY_FIRST);
    lwr(SEL_UNLOCK, 8'h03);
    lwr(SEL_UNLOCK, KEY_SECOND);
    chk(prog_en, 1'b0);
    lwr(SEL_UNLOCK, KEY_FIRST);
    lwr(SEL_UNLOCK, KEY_SECOND);
    chk(prog_en, 1'b1);
    lrd(SEL_UNLOCK, KEY_SECOND);
    lwr(SEL_UNLOCK, 8'h00);
    chk(prog_en, 1'b1);
  endtask

  task automatic t_cmds();
    logic [7:0] codes [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
    int n0;
    frame(OP_ADDR_WR, SEL_DATA_CMD);
    for (int i = 0; i < 4; i++) begin
      n0 = stb_n;
      frame(OP_DATA_WR, codes[i]);
      chk(stb_n, n0 + 1);
      chk({stb_cmd, stb_byte}, {1'b1, codes[i]});
    end
    n0 = stb_n;
    frame(OP_DATA_WR, 8'h05);
    chk(stb_n, n0);
    cmd_rdy <= 1'b0;
    frame(OP_DATA_WR, 8'h05);
    chk({stb_cmd, stb_byte}, {1'b0, 8'h05});
    cmd_rdy <= 1'b1;
    rd_byte <= 8'hC3;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    lrd(SEL_DATA_CMD, 8'hC3);
  endtask

  task automatic t_halt();
    chk(borrowed, 1'b1);
    halted <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(borrowed, 1'b0);
    apb(1'b1, REG_CMD, {16'h0000, SEL_PART_ID, 8'h00});
    chk(perr, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rv[STAT_HALT], 1'b0);
    halted <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(borrowed, 1'b1);
  endtask

  // unmapped read, then a link reset that must relock the flash
  task automatic t_reset();
    int n;
    n = 0;
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({perr, rv}, {1'b1, 32'h0000_0000});
    apb(1'b1, REG_RESET, 32'h0000_0001);
    while (sys_rst !== 1'b1 && n < 400) begin
      n++;
      @(posedge ref_clk);
    end
    chk(sys_rst, 1'b1);
    wait_idle();
    chk(prog_en, 1'b0);
    lrd(SEL_UNLOCK, UNLOCK_RESET);
    lrd(SEL_DATA_CMD, DATA_RESET);
    lrd(SEL_PART_ID, PID);
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ten cycles of srst, then wait out the target's stretched link reset
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    halted = 1'b1;
    cmd_rdy = 1'b1;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
    stb_n = 0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    while (sys_rst !== 1'b0) begin
      @(posedge ref_clk);
    end
    repeat (8 * HD) @(posedge ref_clk);
    t_ids();
    t_unlock();
    t_cmds();
    t_halt();
    t_reset();
    tally_and_finish();
  end

  // hang guard, well past the expected run
  initial begin
    #(60000 * 5);
    mismatches++;
    tally_and_finish();
  end
endmodule
